// ==== logic/scrs_pkg.sv ====
// Package for the sensor configuration register bank: map, categories, reset values, carriers.
// Assumes a 16-bit register word carried in the low half of a 32-bit AXI4-Lite data bus.
package scrs_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 9;
    localparam int IDX_W  = 7;
    localparam int NREG   = 18;

    // Word index is the printed register address; byte address is four times it
    localparam logic [IDX_W-1:0] IDX_MISC            = 7'h00;
    localparam logic [IDX_W-1:0] IDX_LINE_TOTAL      = 7'h01;
    localparam logic [IDX_W-1:0] IDX_IMAGE_FLIP      = 7'h45;
    localparam logic [IDX_W-1:0] IDX_EXPOSURE_LOW    = 7'h47;
    localparam logic [IDX_W-1:0] IDX_FRAME_COUNT     = 7'h50;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_A = 7'h52;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_B = 7'h53;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_C = 7'h54;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_D = 7'h55;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_E = 7'h56;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_F = 7'h57;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_G = 7'h58;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_H = 7'h62;
    localparam logic [IDX_W-1:0] IDX_OVERHEAD_TIMING  = 7'h6B;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_I = 7'h6D;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_J = 7'h71;
    localparam logic [IDX_W-1:0] IDX_READOUT_TUNING_K = 7'h72;
    localparam logic [IDX_W-1:0] IDX_SPAN_CONFIG     = 7'h7D;
    localparam logic [IDX_W-1:0] IDX_SPAN_STATUS     = 7'h7E;

    // Update categories: when a written value reaches the active copy
    typedef enum logic [2:0] {
        CAT_NONE, CAT_SYNC, CAT_FRAME, CAT_EXPO, CAT_INSTANT, CAT_IDLE
    } scrs_cat_t;

    localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{
        IDX_MISC, IDX_LINE_TOTAL, IDX_IMAGE_FLIP, IDX_EXPOSURE_LOW, IDX_FRAME_COUNT,
        IDX_READOUT_TUNING_A, IDX_READOUT_TUNING_B, IDX_READOUT_TUNING_C,
        IDX_READOUT_TUNING_D, IDX_READOUT_TUNING_E, IDX_READOUT_TUNING_F,
        IDX_READOUT_TUNING_G, IDX_READOUT_TUNING_H, IDX_OVERHEAD_TIMING,
        IDX_READOUT_TUNING_I, IDX_READOUT_TUNING_J, IDX_READOUT_TUNING_K,
        IDX_SPAN_CONFIG
    };

    localparam scrs_cat_t REG_CAT [NREG] = '{
        CAT_NONE, CAT_SYNC, CAT_INSTANT, CAT_EXPO, CAT_FRAME,
        CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE,
        CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE, CAT_IDLE,
        CAT_IDLE
    };

    localparam logic [DATA_W-1:0] RST_LINE_TOTAL   = 16'h0C00;
    localparam logic [DATA_W-1:0] RST_EXPOSURE_LOW = 16'h0600;
    localparam logic [DATA_W-1:0] RST_FRAME_COUNT  = 16'h0001;
    localparam logic [DATA_W-1:0] RST_TUNING_A     = 16'h1632;
    localparam logic [DATA_W-1:0] RST_TUNING_B     = 16'h1705;
    localparam logic [DATA_W-1:0] RST_ZERO         = 16'h0000;

    localparam logic [DATA_W-1:0] REG_RST [NREG] = '{
        RST_ZERO, RST_LINE_TOTAL, RST_ZERO, RST_EXPOSURE_LOW, RST_FRAME_COUNT,
        RST_TUNING_A, RST_TUNING_B, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO
    };

    // Span configuration fields
    localparam int SPAN_M1_LSB = 0;
    localparam int SPAN_M2_LSB = 2;
    localparam int SPAN_F_W    = 2;
    localparam logic [SPAN_F_W-1:0] MULT_0 = 2'h0;
    localparam logic [SPAN_F_W-1:0] MULT_1 = 2'h1;
    localparam logic [SPAN_F_W-1:0] MULT_3 = 2'h3;
    localparam int SPAN_TOT_W = 5;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X0  = 5'h00;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X1  = 5'h01;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X2  = 5'h02;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X4  = 5'h04;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X8  = 5'h08;
    localparam logic [SPAN_TOT_W-1:0] SPAN_X16 = 5'h10;
    // Status word: [4:0] total, [5] supported, [6] sensor idle
    localparam int STAT_SUP_BIT  = 5;
    localparam int STAT_IDLE_BIT = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer events, all on aclk; the three events are one-cycle pulses
    typedef struct packed {
        logic idle;
        logic overhead_end;
        logic capture_req;
        logic exposure_start;
    } scrs_seq_t;

    typedef struct packed {
        logic [SPAN_TOT_W-1:0] total;
        logic                  supported;
    } scrs_span_t;

    // Slot holding a word index, or NREG when none does
    function automatic int scrs_find(input logic [IDX_W-1:0] idx);
        int slot;
        slot = NREG;
        for (int i = 0; i < NREG; i++) begin
            if (REG_IDX[i] == idx) begin
                slot = i;
            end
        end
        return slot;
    endfunction

endpackage

// ==== logic/scrs_regbank.sv ====
// Sensor configuration register bank with per-category shadow and active copies.
// Assumes an AXI4-Lite master on aclk and sequencer events on aclk (no synchronisers).
//
// Implementation choice: the AXI4-Lite register port.

`timescale 1ns/1ps
module scrs_regbank
    import scrs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     clk_en,

    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,

    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,

    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,

    // Sequencer events
    input  wire scrs_seq_t                seq,

    // Active settings seen by the sensor
    output logic [NREG-1:0][DATA_W-1:0]   active_regs,
    output scrs_span_t                    span
);

    // Write channel holding state
    logic                  aw_held_reg, aw_held_next;
    logic [ADDR_W-1:0]     awaddr_reg, awaddr_next;
    logic                  w_held_reg, w_held_next;
    logic [DATA_W-1:0]     wdata_reg, wdata_next;
    logic [1:0]            wstrb_reg, wstrb_next;
    logic                  bvalid_reg, bvalid_next;
    logic [1:0]            bresp_reg, bresp_next;

    // Read channel state
    logic                  rvalid_reg, rvalid_next;
    logic [31:0]           rdata_reg, rdata_next;
    logic [1:0]            rresp_reg, rresp_next;

    // Register copies
    logic [NREG-1:0][DATA_W-1:0] shadow_reg, shadow_next;
    logic [NREG-1:0][DATA_W-1:0] active_reg, active_next;
    scrs_span_t            span_reg, span_next;


    // Decode and merge helpers
    logic                  wr_fire;
    int                    wr_slot;
    int                    rd_slot;
    logic [IDX_W-1:0]      wr_idx;
    logic [IDX_W-1:0]      rd_idx;
    logic [DATA_W-1:0]     wr_merged;

    // Span multiplier fields
    logic [SPAN_F_W-1:0]   m1;
    logic [SPAN_F_W-1:0]   m2;

    // Handshakes from holding state; ready drops with the enable
    assign s_axi_awready = clk_en & ~aw_held_reg;
    assign s_axi_wready  = clk_en & ~w_held_reg;
    assign s_axi_arready = clk_en & ~rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Sensor-side views
    assign active_regs   = active_reg;
    assign span          = span_reg;

    // Byte address to word index
    localparam int WORD_LSB = 2;

    // Decode helpers; a write retires only once the previous response has gone
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_idx  = awaddr_reg[ADDR_W-1:WORD_LSB];
    assign rd_idx  = s_axi_araddr[ADDR_W-1:WORD_LSB];
    assign wr_slot = scrs_find(wr_idx);
    assign rd_slot = scrs_find(rd_idx);

    // Byte-lane merge over the 16-bit word
    // Lanes 2 and 3 are dropped
    always_comb begin
        wr_merged = RST_ZERO;
        if (wr_slot < NREG) begin
            wr_merged = shadow_reg[wr_slot];
        end

        if (wstrb_reg[0]) begin
            wr_merged[7:0] = wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
            wr_merged[15:8] = wdata_reg[15:8];
        end
    end

    // AXI write and read channel next state
    always_comb begin
        aw_held_next = aw_held_reg;
        awaddr_next  = awaddr_reg;
        w_held_next  = w_held_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;

        // Address and data are taken in either order
        if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end

        if (s_axi_wvalid && !w_held_reg) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata[DATA_W-1:0];
            wstrb_next  = s_axi_wstrb[1:0];
        end

        // Response leaves once taken
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        // A held response stalls the next commit
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            // Status word is read-only: write dropped, answered OKAY
            if (wr_slot < NREG || wr_idx == IDX_SPAN_STATUS) begin
                bresp_next = RESP_OKAY;
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end

        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end

        // Reads return the last written value, not the active one
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            // Unmapped index: SLVERR, data zero
            if (rd_slot < NREG) begin
                rdata_next[DATA_W-1:0] = shadow_reg[rd_slot];
            end else if (rd_idx == IDX_SPAN_STATUS) begin
                rdata_next[SPAN_TOT_W-1:0] = span_reg.total;
                rdata_next[STAT_SUP_BIT]   = span_reg.supported;
                rdata_next[STAT_IDLE_BIT]  = seq.idle;
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end
    end

    // Shadow and active copies; events first, then the write of this cycle
    always_comb begin
        shadow_next = shadow_reg;
        active_next = active_reg;
        for (int i = 0; i < NREG; i++) begin
            unique case (REG_CAT[i])
                CAT_SYNC: begin
                    if (seq.overhead_end) active_next[i] = shadow_reg[i];
                end
                CAT_FRAME: begin
                    if (seq.capture_req) active_next[i] = shadow_reg[i];
                end
                CAT_EXPO: begin
                    if (seq.exposure_start) active_next[i] = shadow_reg[i];
                end
                CAT_NONE, CAT_INSTANT, CAT_IDLE: begin
                end
            endcase


            // Host write lands in the shadow first
            if (wr_fire && wr_slot == i) begin
                shadow_next[i] = wr_merged;
                // Write landing on its sync event: the new value goes live
                if (REG_CAT[i] == CAT_NONE) begin
                    active_next[i] = wr_merged;
                end else if (REG_CAT[i] == CAT_INSTANT || REG_CAT[i] == CAT_IDLE) begin
                    active_next[i] = wr_merged;
                end else if ((REG_CAT[i] == CAT_SYNC && seq.overhead_end)
                          || (REG_CAT[i] == CAT_FRAME && seq.capture_req)
                          || (REG_CAT[i] == CAT_EXPO && seq.exposure_start)) begin
                    active_next[i] = wr_merged;
                end
            end
        end
    end

    // Range multiplier decode from the active span configuration
    always_comb begin
        m1 = active_reg[scrs_find(IDX_SPAN_CONFIG)][SPAN_M1_LSB +: SPAN_F_W];
        m2 = active_reg[scrs_find(IDX_SPAN_CONFIG)][SPAN_M2_LSB +: SPAN_F_W];

        // Supported until no pairing matches
        span_next.total     = SPAN_X0;
        span_next.supported = 1'b1;
        if (m2 == MULT_0 && m1 == MULT_0) begin
            span_next.total = SPAN_X1;
        end else if (m2 == MULT_0 && m1 == MULT_1) begin
            span_next.total = SPAN_X2;
        end else if (m2 == MULT_0 && m1 == MULT_3) begin
            span_next.total = SPAN_X4;
        end else if (m1 == MULT_3 && m2 == MULT_1) begin
            span_next.total = SPAN_X8;
        end else if (m1 == MULT_3 && m2 == MULT_3) begin
            span_next.total = SPAN_X16;
        end else begin
            // Unsupported pairing: factor reads zero and the flag drops
            span_next.supported = 1'b0;
        end
    end

    // All state registers; clock enable low freezes everything except reset, which still loads the defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_held_reg  <= 1'b0;
            wdata_reg   <= RST_ZERO;
            wstrb_reg   <= 2'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;

            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;

            // Defaults from the package table
            for (int i = 0; i < NREG; i++) begin
                shadow_reg[i] <= REG_RST[i];
                active_reg[i] <= REG_RST[i];
            end
            // Decode of an all-zero config
            span_reg.total     <= SPAN_X1;
            span_reg.supported <= 1'b1;
        end else if (clk_en) begin
            aw_held_reg <= aw_held_next;
            awaddr_reg  <= awaddr_next;
            w_held_reg  <= w_held_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;

            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;

            shadow_reg  <= shadow_next;
            active_reg  <= active_next;
            span_reg    <= span_next;
        end
    end

endmodule

// ==== verification/scrs_host.sv ====
// Host controller model: register bus master with one write and one read task.
// Assumes the bank shares aclk; tasks are entered just after a rising edge.
`timescale 1ns/1ps
module scrs_host
    import scrs_pkg::*;
(
    // Clock and sensor state
    input  wire logic         aclk,
    input  wire logic         idle,
    // Write channels
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic              s_axi_awvalid,
    input  wire logic         s_axi_awready,
    output logic [31:0]       s_axi_wdata,
    output logic              s_axi_wvalid,
    input  wire logic         s_axi_wready,
    input  wire logic [1:0]   s_axi_bresp,
    input  wire logic         s_axi_bvalid,
    output logic              s_axi_bready,
    // Read channels
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic              s_axi_arvalid,
    input  wire logic         s_axi_arready,
    input  wire logic [31:0]  s_axi_rdata,
    input  wire logic [1:0]   s_axi_rresp,
    input  wire logic         s_axi_rvalid,
    output logic              s_axi_rready
);
    // Answers always accepted, so ready never toggles between transfers
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    end

    // Slower clock: only [13:7] moves, given in tenths, rounded down
    function automatic logic [15:0] overhead_for(input int tenths);
        return {2'h0, 7'(tenths / 10), 7'h5E};
    endfunction

    // One write; released lines are inverted so stale values never look valid
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v, input bit any,
                      output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        while (!any && !idle) @(posedge aclk);  // Only in an allowed window
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask

    // One read, held until taken, answer picked up at the rvalid edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] resp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        v    = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
endmodule

// ==== verification/scrs_regbank_sva.sv ====
// Checker for the register bank: commit timing, category events, defaults, span decode.
// Assumes one clock; no category event falls in the cycle in which a write commits.
`timescale 1ns/1ps
module scrs_regbank_sva
    import scrs_pkg::*;
(
    // Clock and control
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        clk_en,
    // Write side of the register bus
    input wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic [31:0]                 s_axi_wdata,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    // Sequencer and active settings
    input wire scrs_seq_t                   seq,
    input wire logic [NREG-1:0][DATA_W-1:0] active_regs,
    input wire scrs_span_t                  span
);
    logic [IDX_W-1:0]  ai;
    logic [DATA_W-1:0] wd, sh_line, sh_expo;
    logic              bq;
    wire               cm = s_axi_bvalid && !bq;  // First cycle of a write answer

    // Last write and the shadows expected behind the line total and exposure slots
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bq      <= 1'b0;
            sh_line <= 16'h0C00;
            sh_expo <= 16'h0600;
        end else if (clk_en) begin
            bq <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) ai <= s_axi_awaddr[ADDR_W-1:2];
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[DATA_W-1:0];
            if (cm && ai == IDX_LINE_TOTAL) sh_line <= wd;
            if (cm && ai == IDX_EXPOSURE_LOW) sh_expo <= wd;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Immediate slots show the word once the answer is up
    property p_misc_now; cm && ai == IDX_MISC |-> active_regs[0] == wd; endproperty
    a_misc_now: assert property (p_misc_now) else $error("misc write not live");
    property p_flip_now; cm && ai == IDX_IMAGE_FLIP |-> active_regs[2] == wd; endproperty
    a_flip_now: assert property (p_flip_now) else $error("flip write not live");
    // Status write leaves every setting alone
    property p_ro_write;
        cm && ai == IDX_SPAN_STATUS |-> s_axi_bresp == RESP_OKAY && $stable(active_regs);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status write had an effect");
    // Line total and frame count move only at their own event; line total and exposure take their shadow there
    property p_line_hold; !seq.overhead_end |=> $stable(active_regs[1]); endproperty
    a_line_hold: assert property (p_line_hold) else $error("line total moved early");
    property p_frame_hold; !seq.capture_req |=> $stable(active_regs[4]); endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame count moved early");
    property p_line_sync; seq.overhead_end && clk_en |=> active_regs[1] == sh_line; endproperty
    a_line_sync: assert property (p_line_sync) else $error("line total not synced");
    property p_expo_sync; seq.exposure_start && clk_en |=> active_regs[3] == sh_expo; endproperty
    a_expo_sync: assert property (p_expo_sync) else $error("exposure not synced");
    // Widest span setting decodes to sixteen
    property p_span16;
        active_regs[17][3:0] == 4'hF && clk_en |=> span.total == 5'h10 && span.supported;
    endproperty
    a_span16: assert property (p_span16) else $error("span x16 wrong");
    // Reset itself is checked, so this one is never disabled
    property p_defaults;
        disable iff (1'b0) !aresetn && clk_en |=> active_regs[1] == 16'h0C00
            && active_regs[3] == 16'h0600 && active_regs[4] == 16'h0001;
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset values wrong");
endmodule

// ==== verification/scrs_regbank_tb.sv ====
// Bench for the register bank: host model on the bus, sequencer events from here.
// Assumes the checker is bound to the bank; byte strobes stay high.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
bind scrs_regbank scrs_regbank_sva scrs_regbank_sva_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .seq, .active_regs, .span);
module scrs_regbank_tb;
    import scrs_pkg::*;
    logic                        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    scrs_seq_t                   seq = '0;
    logic [ADDR_W-1:0]           s_axi_awaddr, s_axi_araddr;
    logic [31:0]                 s_axi_wdata, s_axi_rdata, d;
    logic [1:0]                  s_axi_bresp, s_axi_rresp, r;
    logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                        s_axi_rvalid, s_axi_rready;
    logic [NREG-1:0][DATA_W-1:0] act;
    scrs_span_t                  span;
    int                          error_cnt = 0, compares = 0;

    // 125 MHz clock
    always #4 aclk = ~aclk;

    scrs_regbank scrs_regbank_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq,
        .active_regs(act), .span);
    scrs_host scrs_host_i (.aclk, .idle(seq.idle), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
        return {i, 2'h0};
    endfunction

    task automatic pulse(int k);  // 0 overhead end, 1 capture request, 2 exposure start
        seq[2:0] <= 3'h4 >> k;
        @(posedge aclk);
        seq[2:0] <= 3'h0;
        @(posedge aclk);
    endtask

    task automatic t_reset(int n);  // hold reset, then read the defaults back
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn  <= 1'b1;
        seq.idle <= 1'b1;
        @(posedge aclk);
        scrs_host_i.rd(ba(IDX_LINE_TOTAL), d, r);
        `CHK("line_total", 32'h0000_0C00, d)
        scrs_host_i.rd(ba(IDX_EXPOSURE_LOW), d, r);
        `CHK("exposure_low", 32'h0000_0600, d)
        `CHK("frame_count", 16'h0001, act[4])
    endtask

    task automatic t_immediate;  // misc mid-frame, then instant and idle slots
        seq.idle <= 1'b0;
        scrs_host_i.wr(ba(IDX_MISC), 16'h00C3, 1'b1, r);
        `CHK("misc", 16'h00C3, act[0])
        seq.idle <= 1'b1;
        scrs_host_i.wr(ba(IDX_IMAGE_FLIP), 16'h0003, 1'b0, r);
        `CHK("image_flip", 16'h0003, act[2])
        scrs_host_i.wr(ba(IDX_READOUT_TUNING_H), 16'h9A09, 1'b0, r);
        `CHK("tuning_h", 16'h9A09, act[12])
        scrs_host_i.wr(ba(IDX_OVERHEAD_TIMING), scrs_host_i.overhead_for(805), 1'b0, r);
        `CHK("overhead", 16'h285E, act[13])
    endtask

    task automatic t_deferred;  // shadow held through a foreign event, applied at its own
        logic [IDX_W-1:0]  ix [3] = '{IDX_LINE_TOTAL, IDX_FRAME_COUNT, IDX_EXPOSURE_LOW};
        logic [DATA_W-1:0] v [3] = '{16'hA5C3, 16'h0005, 16'h3C5A};
        int                sl [3] = '{1, 4, 3};
        logic [DATA_W-1:0] old;
        for (int k = 0; k < 3; k++) begin
            old = act[sl[k]];
            scrs_host_i.wr(ba(ix[k]), v[k], 1'b0, r);
            `CHK("held", old, act[sl[k]])
            scrs_host_i.rd(ba(ix[k]), d, r);
            `CHK("shadow", {16'h0000, v[k]}, d)
            pulse((k + 1) % 3);
            `CHK("foreign_event", old, act[sl[k]])
            pulse(k);
            `CHK("applied", v[k], act[sl[k]])
        end
        // Enable low: the event is lost
        scrs_host_i.wr(ba(IDX_LINE_TOTAL), 16'h1234, 1'b0, r);
        clk_en <= 1'b0;
        pulse(0);
        `CHK("frozen", 16'hA5C3, act[1])
        clk_en <= 1'b1;
        pulse(0);
        `CHK("thawed", 16'h1234, act[1])
    endtask

    task automatic t_span;  // every multiplier pair against the decoded total
        logic [4:0] e;
        for (int c = 0; c < 16; c++) begin
            scrs_host_i.wr(ba(IDX_SPAN_CONFIG), 16'(c), 1'b0, r);
            e = c == 0 ? 5'h01 : c == 1 ? 5'h02 : c == 3 ? 5'h04 :
                c == 7 ? 5'h08 : c == 15 ? 5'h10 : 5'h00;
            scrs_host_i.rd(ba(IDX_SPAN_STATUS), d, r);
            `CHK("span", {e != 5'h00, e}, d[5:0])
            `CHK("span_out", e, span.total)
        end
    endtask

    task automatic t_refuse;  // status write ignored, unmapped word refused
        scrs_host_i.wr(ba(IDX_SPAN_STATUS), 16'h0000, 1'b0, r);
        `CHK("ro_resp", RESP_OKAY, r)
        scrs_host_i.rd(ba(IDX_SPAN_STATUS), d, r);
        `CHK("ro_word", 32'h0000_0070, d)
        scrs_host_i.rd(ba(7'h7F), d, r);
        `CHK("unmapped_resp", RESP_SLVERR, r)
        `CHK("unmapped_data", 32'h0000_0000, d)
        scrs_host_i.wr(ba(7'h7F), 16'h0000, 1'b0, r);
        `CHK("unmapped_wr", RESP_SLVERR, r)
    endtask

    task automatic finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence, second reset last to see defaults come back
    initial begin
        t_reset(12);
        t_immediate;
        t_deferred;
        t_span;
        t_refuse;
        t_reset(2);
        finish_test;
    end

    // Watchdog; the run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        finish_test;
    end
endmodule
